// ### rdsl_regs.sv
/*
 * Register bank for radio debug pin configuration, sync word, packet
 * length and the frequency offset estimate.
 * Assumes a single 200 MHz core clock, a plain strobe register port, and
 * that the radio datapath supplies a sampled frequency offset.
 */
// Strobed register access was chosen for this implementation.
// Functional notes
// - Each of the three debug pins has a six-bit select field that resets to zero.
// - Bit 6 of each debug configuration inverts the pin, set meaning active low.
// - Bit 7 of the middle debug configuration picks minimum or maximum pin drive.
// - The sync word is sixteen bits from a high byte 0xD3 and a low byte 0x91.
// - The packet length byte, reset 0xFF, is exact or maximum by length mode.
// - The measured receive frequency offset is readable by software.
`timescale 1ns/1ps
module rdsl_regs (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [63:0] radio_signals_in,
    input wire logic rx_active_in,
    input wire logic freq_est_valid_in,
    input wire logic [7:0] freq_est_in,
    output logic [2:0] debug_pins_out,
    output logic debug_drive_strength_out,
    output logic [15:0] sync_word_out,
    output logic [7:0] packet_length_limit_out
);
    rdsl_pkg::rdsl_state_t state_reg;
    rdsl_pkg::rdsl_state_t state_next;
    rdsl_pkg::rdsl_bus_req_t req;
    logic [2:0] pin_raw;

    // ------------------------------------------------------------
    // Bus request bundle
    // ------------------------------------------------------------
    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // Address decode shared by write and read paths
    function automatic int dbg_index(input logic [15:0] a);
        unique case (a)
            rdsl_pkg::DBG_A_ADDR: dbg_index = 0;
            rdsl_pkg::DBG_B_ADDR: dbg_index = 1;
            rdsl_pkg::DBG_C_ADDR: dbg_index = 2;
            default: dbg_index = -1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Debug pin selectors
    // ------------------------------------------------------------
    for (genvar i = 0; i < rdsl_pkg::NUM_DBG; i++) begin : g_pin
        rdsl_pin_mux u_mux (
            .signals_in(radio_signals_in),
            .select_in(state_reg.dbg[i].select),
            .polarity_in(state_reg.dbg[i].polarity),
            .pin_out(pin_raw[i])
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        int idx;
        idx = dbg_index(req.addr);
        state_next = state_reg;
        // Pins registered so data outputs come from flip-flops
        state_next.dbg_pins = pin_raw;
        // Estimate only updates while receiving, holds the last result
        if (rx_active_in && freq_est_valid_in) begin
            state_next.freq_est = freq_est_in;
        end
        if (req.wr) begin
            if (idx >= 0) begin
                // Bit 7 stored only in the middle register
                state_next.dbg[idx].polarity = req.wdata[rdsl_pkg::POL_BIT];
                state_next.dbg[idx].select = req.wdata[rdsl_pkg::SEL_MSB:0];
                if (idx == 1) begin
                    state_next.drive_strength = req.wdata[rdsl_pkg::DRV_BIT];
                end
            end
            unique case (req.addr)
                rdsl_pkg::SYNC_HIGH_ADDR: state_next.sync_high = req.wdata;
                rdsl_pkg::SYNC_LOW_ADDR: state_next.sync_low = req.wdata;
                rdsl_pkg::PKT_LEN_ADDR: state_next.pkt_len = req.wdata;
                default: ;
            endcase
        end
        // Read data valid only the cycle after the strobe
        state_next.rdata = rdsl_pkg::ZERO_BYTE;
        if (req.rd) begin
            if (idx >= 0) begin
                // Outer registers return zero in bit 7
                state_next.rdata = {(idx == 1) ? state_reg.drive_strength : 1'b0,
                                    state_reg.dbg[idx]};
            end else begin
                unique case (req.addr)
                    rdsl_pkg::SYNC_HIGH_ADDR: state_next.rdata = state_reg.sync_high;
                    rdsl_pkg::SYNC_LOW_ADDR: state_next.rdata = state_reg.sync_low;
                    rdsl_pkg::PKT_LEN_ADDR: state_next.rdata = state_reg.pkt_len;
                    rdsl_pkg::FREQ_EST_ADDR: state_next.rdata = state_reg.freq_est;
                    default: state_next.rdata = rdsl_pkg::ZERO_BYTE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= '0;
            for (int i = 0; i < rdsl_pkg::NUM_DBG; i++) begin
                state_reg.dbg[i].select <= rdsl_pkg::SEL_RESET;
            end
            state_reg.sync_high <= rdsl_pkg::SYNC_HIGH_RESET;
            state_reg.sync_low <= rdsl_pkg::SYNC_LOW_RESET;
            state_reg.pkt_len <= rdsl_pkg::PKT_LEN_RESET;
        end else if (clk_en_in) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_out = state_reg.rdata;
    assign debug_pins_out = state_reg.dbg_pins;
    assign debug_drive_strength_out = state_reg.drive_strength;
    assign sync_word_out = {state_reg.sync_high, state_reg.sync_low};
    // Length mode lives in packet control, outside this bank
    assign packet_length_limit_out = state_reg.pkt_len;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Register writes land one cycle after the strobe
    a_sync_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && wr_in && addr_in == rdsl_pkg::SYNC_HIGH_ADDR
        |=> sync_word_out[15:8] == $past(wdata_in))
        else $error("sync high byte not written");
    a_sync_low_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && wr_in && addr_in == rdsl_pkg::SYNC_LOW_ADDR
        |=> sync_word_out[7:0] == $past(wdata_in))
        else $error("sync low byte not written");
    a_len_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && wr_in && addr_in == rdsl_pkg::PKT_LEN_ADDR
        |=> packet_length_limit_out == $past(wdata_in))
        else $error("packet length not written");
    a_drive_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && wr_in && addr_in == rdsl_pkg::DBG_B_ADDR
        |=> debug_drive_strength_out == $past(wdata_in[rdsl_pkg::DRV_BIT]))
        else $error("drive strength not written");
    a_select_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && wr_in && addr_in == rdsl_pkg::DBG_C_ADDR
        |=> state_reg.dbg[2].select == $past(wdata_in[rdsl_pkg::SEL_MSB:0]))
        else $error("select field not written");
    // Only the middle register may move the drive strength
    a_drive_keep: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && wr_in
        && (addr_in == rdsl_pkg::DBG_A_ADDR || addr_in == rdsl_pkg::DBG_C_ADDR)
        |=> $stable(debug_drive_strength_out))
        else $error("outer write moved drive strength");

    // Each pin shows its chosen signal, inverted when polarity is set
    a_pin_polarity: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in |=> debug_pins_out[0] ==
        ($past(radio_signals_in[state_reg.dbg[0].select]) ^ $past(state_reg.dbg[0].polarity)))
        else $error("debug pin polarity wrong");
    a_pin_b_level: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in |=> debug_pins_out[1] ==
        ($past(radio_signals_in[state_reg.dbg[1].select]) ^ $past(state_reg.dbg[1].polarity)))
        else $error("middle debug pin level wrong");
    a_pin_c_level: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in |=> debug_pins_out[2] ==
        ($past(radio_signals_in[state_reg.dbg[2].select]) ^ $past(state_reg.dbg[2].polarity)))
        else $error("third debug pin level wrong");

    // Read data reflects the register as it stood at the strobe
    a_sel_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && rd_in && addr_in == rdsl_pkg::DBG_A_ADDR && !wr_in
        |=> rdata_out[rdsl_pkg::SEL_MSB:0] == $past(state_reg.dbg[0].select))
        else $error("select readback wrong");
    a_unused_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && rd_in
        && (addr_in == rdsl_pkg::DBG_A_ADDR || addr_in == rdsl_pkg::DBG_C_ADDR)
        |=> rdata_out[rdsl_pkg::DRV_BIT] == 1'b0)
        else $error("unused bit reads one");
    a_polarity_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && rd_in && addr_in == rdsl_pkg::DBG_B_ADDR
        |=> rdata_out[rdsl_pkg::POL_BIT] == $past(state_reg.dbg[1].polarity))
        else $error("polarity readback wrong");
    a_len_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && rd_in && addr_in == rdsl_pkg::PKT_LEN_ADDR
        |=> rdata_out == $past(packet_length_limit_out))
        else $error("packet length readback wrong");
    a_sync_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && rd_in && addr_in == rdsl_pkg::SYNC_LOW_ADDR
        |=> rdata_out == $past(sync_word_out[7:0]))
        else $error("sync low byte readback wrong");

    // Estimate captured while receiving, held at all other times
    a_freq_capture: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && rx_active_in && freq_est_valid_in ##1 clk_en_in && rd_in
        && addr_in == rdsl_pkg::FREQ_EST_ADDR && !(rx_active_in && freq_est_valid_in)
        |=> rdata_out == $past(freq_est_in, 2))
        else $error("frequency estimate not readable");
    a_freq_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
        clk_en_in && !rx_active_in |=> $stable(state_reg.freq_est))
        else $error("estimate changed outside receive");

    // A low clock enable freezes the whole bank, strobes included
    a_freeze_sync: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !clk_en_in |=> $stable(sync_word_out))
        else $error("sync word moved while frozen");
    a_freeze_len: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !clk_en_in |=> $stable(packet_length_limit_out))
        else $error("packet length moved while frozen");
endmodule

// ### rdsl_pkg.sv
/*
 * Package for the radio debug, sync word and packet length register bank.
 * Holds register offsets, field positions, reset values and the structs
 * that carry register contents and bus requests. Assumes an 8-bit
 * register port addressed by 16-bit byte addresses.
 */
package rdsl_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] SYNC_HIGH_ADDR = 16'hdf00;
    localparam logic [15:0] SYNC_LOW_ADDR = 16'hdf01;
    localparam logic [15:0] PKT_LEN_ADDR = 16'hdf02;
    localparam logic [15:0] DBG_C_ADDR = 16'hdf2f;
    localparam logic [15:0] DBG_B_ADDR = 16'hdf30;
    localparam logic [15:0] DBG_A_ADDR = 16'hdf31;
    localparam logic [15:0] FREQ_EST_ADDR = 16'hdf40;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int SEL_MSB = 5;
    localparam int POL_BIT = 6;
    localparam int DRV_BIT = 7;
    localparam int NUM_DBG = 3;
    localparam logic [5:0] SEL_RESET = 6'h00;
    localparam logic [7:0] SYNC_HIGH_RESET = 8'hd3;
    localparam logic [7:0] SYNC_LOW_RESET = 8'h91;
    localparam logic [7:0] PKT_LEN_RESET = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // One debug pin configuration
    typedef struct packed {
        logic polarity;
        logic [5:0] select;
    } rdsl_dbg_cfg_t;

    // Register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rdsl_bus_req_t;

    // Whole module state
    typedef struct packed {
        rdsl_dbg_cfg_t [2:0] dbg;
        logic drive_strength;
        logic [7:0] sync_high;
        logic [7:0] sync_low;
        logic [7:0] pkt_len;
        logic [7:0] freq_est;
        logic [7:0] rdata;
        logic [2:0] dbg_pins;
    } rdsl_state_t;

endpackage

// ### rdsl_pin_mux.sv
/*
 * Debug pin source selector: picks one of 64 internal radio signals by a
 * six-bit select and applies the polarity inversion.
 * Assumes the signal vector is synchronous to the core clock.
 */
`timescale 1ns/1ps
module rdsl_pin_mux (
    input wire logic [63:0] signals_in,
    input wire logic [5:0] select_in,
    input wire logic polarity_in,
    output logic pin_out
);
    // Invert when polarity is set, giving an active low output
    assign pin_out = signals_in[select_in] ^ polarity_in;
endmodule

// ### rdsl_regs_tb.sv
/*
 * Self-checking testbench for the radio debug, sync word and length bank.
 * Assumes the strobe register port with read data one cycle after rd_in.
 */
`timescale 1ns/1ps
module rdsl_regs_tb;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [63:0] radio_signals_in = 64'h0000_0000_0000_0000;
    logic rx_active_in = 1'b0;
    logic freq_est_valid_in = 1'b0;
    logic [7:0] freq_est_in = 8'h00;
    logic [7:0] rdata_out;
    logic [2:0] debug_pins_out;
    logic debug_drive_strength_out;
    logic [15:0] sync_word_out;
    logic [7:0] packet_length_limit_out;
    logic [15:0] addr_tab [7] = '{16'hdf00, 16'hdf01, 16'hdf02, 16'hdf2f, 16'hdf30,
        16'hdf31, rdsl_pkg::FREQ_EST_ADDR};
    logic [7:0] m [7] = '{8'hd3, 8'h91, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    int idx;
    int errors = 0;
    int n_checks = 0;

    rdsl_regs u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .radio_signals_in(radio_signals_in),
        .rx_active_in(rx_active_in), .freq_est_valid_in(freq_est_valid_in),
        .freq_est_in(freq_est_in), .debug_pins_out(debug_pins_out),
        .debug_drive_strength_out(debug_drive_strength_out),
        .sync_word_out(sync_word_out), .packet_length_limit_out(packet_length_limit_out));

    // ----------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ----------------------------------------------------------------
    initial begin
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge core_clk_in);
        errors++;
        finish_test();
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1 chk(16'(rdata_out), 16'(exp), "read data");
    endtask

    // Pin level is the chosen signal, inverted when polarity is set
    function automatic logic pin_exp(input logic [63:0] s, input logic [7:0] cfg);
        return s[cfg[5:0]] ^ cfg[6];
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h7b8b));
        repeat (12) @(posedge core_clk_in);
        rst_in <= 1'b0;
        #1 chk(sync_word_out, 16'hd391, "sync reset");
        chk(16'(packet_length_limit_out), 16'h00ff, "length reset");
        chk(16'({debug_drive_strength_out, debug_pins_out}), 16'h0000, "pins reset");
        for (int i = 0; i < 7; i++) rd_chk(addr_tab[i], m[i]);
        @(posedge core_clk_in);
        #1 chk(16'(rdata_out), 16'h0000, "read data idle");
        $display("test reset done");
        // Random writes, outer configs lose bit 7, pins follow config
        for (int n = 0; n < 40; n++) begin
            idx = $urandom_range(0, 5);
            d = 8'($urandom);
            wr_reg(addr_tab[idx], d);
            m[idx] = (idx == 3 || idx == 5) ? (d & 8'h7f) : d;
            rd_chk(addr_tab[idx], m[idx]);
            chk(sync_word_out, {m[0], m[1]}, "sync word");
            chk(16'(packet_length_limit_out), 16'(m[2]), "length");
            chk(16'(debug_drive_strength_out), 16'(m[4][7]), "drive");
            @(posedge core_clk_in);
            radio_signals_in <= {$urandom, $urandom};
            @(posedge core_clk_in);
            #1 chk(16'(debug_pins_out), 16'({pin_exp(radio_signals_in, m[3]),
                pin_exp(radio_signals_in, m[4]), pin_exp(radio_signals_in, m[5])}),
                "pins");
        end
        $display("test random access done");
        // Refused writes: status, unmapped place, clock enable low
        wr_reg(rdsl_pkg::FREQ_EST_ADDR, 8'h5a);
        rd_chk(rdsl_pkg::FREQ_EST_ADDR, 8'h00);
        wr_reg(16'hdf10, 8'h3c);
        rd_chk(16'hdf10, 8'h00);
        // Parked as in a sleep mode: a write with the enable low must not land
        @(posedge core_clk_in);
        clk_en_in <= 1'b0;
        wr_reg(16'hdf02, ~m[2]);
        clk_en_in <= 1'b1;
        rd_chk(16'hdf02, m[2]);
        chk(sync_word_out, {m[0], m[1]}, "sync kept");
        $display("test refusals done");
        // Offset estimate taken only while receiving
        d = 8'($urandom);
        @(posedge core_clk_in);
        rx_active_in <= 1'b1;
        freq_est_valid_in <= 1'b1;
        freq_est_in <= d;
        @(posedge core_clk_in);
        rx_active_in <= 1'b0;
        freq_est_in <= ~d;
        addr_in <= rdsl_pkg::FREQ_EST_ADDR;
        rd_in <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1 chk(16'(rdata_out), 16'(d), "estimate right after capture");
        // Valid stays high with the receiver off: the stored value must hold
        rd_chk(rdsl_pkg::FREQ_EST_ADDR, d);
        $display("test offset estimate done");
        finish_test();
    end
endmodule
